//--- design/msg_irq_pkg.sv
// Package for the message completion interrupt block.
// Assumes a single 10 MHz clock and an AXI4-Lite master with 32-bit data.
package msg_irq_pkg;

    // Bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PACE_W = 16;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_COMP_PTR = 8'h00;  // Completion pointer
    localparam logic [ADDR_W-1:0] OFF_PACING   = 8'h04;  // Interrupt pacing countdown
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h08;  // Status flags
    localparam logic [ADDR_W-1:0] OFF_MASK     = 8'h0c;  // Interrupt mask

    // Status and mask bit positions
    localparam int BIT_PENDING  = 0;  // Completion condition bit
    localparam int BIT_MISMATCH = 1;  // Pointer write that did not match
    localparam int BIT_LOST     = 2;  // Set lost to a colliding clear
    localparam int FLAG_W       = 3;

    // Reset values
    localparam logic [DATA_W-1:0] RST_PTR  = 32'h0000_0000;
    localparam logic [PACE_W-1:0] RST_PACE = 16'h0000;
    localparam logic [FLAG_W-1:0] RST_MASK = 3'h1;

    // Bus response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Register selector produced by address decode
    typedef enum logic [2:0] {
        SEL_PTR,
        SEL_PACE,
        SEL_STATUS,
        SEL_MASK,
        SEL_NONE
    } reg_sel_t;

    // Message completion sequence
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_DESC,
        PH_SET,
        PH_PTR
    } phase_t;

    // Master to slave signals
    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [DATA_W-1:0] wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } axi_req_t;

    // Slave to master signals
    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
    } axi_rsp_t;

    // Descriptor store request toward buffer memory
    typedef struct packed {
        logic              we;
        logic [DATA_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } desc_wr_t;

endpackage

//--- design/msg_irq.sv
// Message completion interrupt with pointer handshake and pacing re-arm.
// Holds the completion sequence, the register slave and the interrupt output.
// One clock domain and one asynchronous active-low reset throughout.
// Assumes message events come from logic on the same clock and an
// AXI4-Lite master that keeps one write and one read under way at most.
`timescale 1ns/1ps
`default_nettype none

// What this block and its software do
// RL1: Clear beats set on pending bit
// RL2: Store descriptor, set bit, then pointer
// RL3: Software ends by writing completion pointer
// RL4: Matching pointer write clears pending interrupt
// RL5: Mismatch keeps pending; refires after pacing
// RL6: Same-cycle match and set loses interrupt
// RL7: Lost interrupt keeps descriptor data intact
// RL8: Later completion raises interrupt normally
// RL9: Handler checks source is descriptor interface
// RL10: Software fetches descriptor, tests ownership
// RL11: End of queue: write pointer, re-arm
// RL12: Owned descriptors: advance tracking pointer, repeat
// RL13: Not owned: write pointer from tracking
// RL14: Recheck ownership after pointer write
// RL15: Finish by writing pacing register
module msg_irq (
    input  wire logic                           i_clock,
    input  wire logic                           i_nrst,
    input  wire msg_irq_pkg::axi_req_t          i_axi,
    output var  msg_irq_pkg::axi_rsp_t          o_axi,
    input  wire logic                           i_msg_valid,
    input  wire logic [msg_irq_pkg::DATA_W-1:0] i_msg_desc_addr,
    input  wire logic [msg_irq_pkg::DATA_W-1:0] i_msg_desc_info,
    output var  logic                           o_msg_ready,
    output var  msg_irq_pkg::desc_wr_t          o_desc,
    output var  logic                           o_irq
);
    import msg_irq_pkg::*;

    // Whole state of the block
    // Every field is registered together, so the outputs below are plain
    // slices of one flip-flop bank and never see combinational glitches.
    typedef struct packed {
        phase_t             phase;       // Completion sequence step
        logic [DATA_W-1:0]  cap_addr;    // Descriptor address in flight
        logic [DATA_W-1:0]  cap_info;    // Descriptor info in flight
        logic [DATA_W-1:0]  dev_ptr;     // Device completion pointer
        logic [FLAG_W-1:0]  flags;       // Status bits
        logic [FLAG_W-1:0]  mask;        // Interrupt mask
        logic [PACE_W-1:0]  pace_cnt;    // Pacing countdown
        logic               armed;       // Pacing expired, pending bit may fire irq
        logic               aw_got;      // Write address held
        logic [ADDR_W-1:0]  awaddr;      // Held write address
        logic               w_got;       // Write data held
        logic [DATA_W-1:0]  wdata;       // Held write data
        logic [3:0]         wstrb;       // Held byte enables
        axi_rsp_t           rsp;         // Bus outputs
        desc_wr_t           desc;        // Descriptor store outputs
        logic               msg_ready;   // Ready for next message
        logic               irq;         // Interrupt output
    } state_t;

    state_t state;       // Registered state
    state_t next_state;  // Next value

    // Map a byte address to a register
    // Unmapped or unaligned addresses fall through to an error selector
    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
        case (addr)
            OFF_COMP_PTR: decode = SEL_PTR;
            OFF_PACING:   decode = SEL_PACE;
            OFF_STATUS:   decode = SEL_STATUS;
            OFF_MASK:     decode = SEL_MASK;
            default:      decode = SEL_NONE;
        endcase
    endfunction

    // Expand byte enables into a bit mask
    // One mask bit per data bit, eight per strobe
    function automatic logic [DATA_W-1:0] strb_mask(input logic [3:0] strb);
        strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    // Merge new data into old under byte enables
    // Lanes with a low strobe keep their old contents
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                                input logic [DATA_W-1:0] new_v,
                                                input logic [3:0]        strb);
        merge = (old_v & ~strb_mask(strb)) | (new_v & strb_mask(strb));
    endfunction

    // Next-state logic: bus slave, completion sequence, pacing, interrupt
    // The pending bit keeps the known priority: a matching pointer write
    // in the same cycle as the set step wins and the set is dropped.
    // Software recovers on the next completion or by walking descriptors;
    // the dropped set is still flagged in the status register.
    always_comb begin
        logic              do_write;   // Buffered write executes now
        reg_sel_t          wsel;       // Target of the write
        logic [DATA_W-1:0] wval;       // Merged write value for pointer
        logic [DATA_W-1:0] w1c;        // Bits written as one
        logic              ptr_wr;     // Completion pointer written
        logic              ptr_match;  // Written pointer equals device one
        logic              set_req;    // Sequence sets pending bit now
        logic [DATA_W-1:0] pace_val;   // Merged pacing value
        reg_sel_t          rsel;       // Target of the read
        // Defaults for every local on every path
        do_write   = 1'b0;
        wsel       = SEL_NONE;
        wval       = '0;
        w1c        = '0;
        ptr_wr     = 1'b0;
        ptr_match  = 1'b0;
        set_req    = 1'b0;
        pace_val   = '0;
        rsel       = SEL_NONE;
        // Start from the held state and change only what moves
        next_state = state;

        // Capture write address and data in either order
        if (i_axi.awvalid && state.rsp.awready) begin
            // Address half taken; held until the write executes
            next_state.aw_got = 1'b1;
            next_state.awaddr = i_axi.awaddr;
        end
        if (i_axi.wvalid && state.rsp.wready) begin
            // Data half taken with its byte enables
            next_state.w_got = 1'b1;
            next_state.wdata = i_axi.wdata;
            next_state.wstrb = i_axi.wstrb;
        end

        // Write response handshake
        if (state.rsp.bvalid && i_axi.bready) begin
            // Master has taken the response
            next_state.rsp.bvalid = 1'b0;
        end

        // Execute a write once both halves are held
        // Waiting for a free response slot keeps one write under way
        if (state.aw_got && state.w_got && !state.rsp.bvalid) begin
            do_write              = 1'b1;
            wsel                  = decode(state.awaddr);
            next_state.aw_got     = 1'b0;
            next_state.w_got      = 1'b0;
            next_state.rsp.bvalid = 1'b1;
            next_state.rsp.bresp  = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        // Write values prepared for every register target
        wval     = merge(state.dev_ptr, state.wdata, state.wstrb);
        w1c      = state.wdata & strb_mask(state.wstrb);
        pace_val = merge({{(DATA_W-PACE_W){1'b0}}, state.pace_cnt}, state.wdata, state.wstrb);
        ptr_wr   = do_write && (wsel == SEL_PTR);

        // RL4 pointer compare
        // Compared with the pointer before the sequence moves it
        ptr_match = ptr_wr && (wval == state.dev_ptr);

        // RL2 ordered completion sequence
        // Store pulse lasts one cycle unless the sequence raises it
        next_state.desc.we = 1'b0;
        case (state.phase)
            PH_IDLE: begin
                // Take a finished message and keep its descriptor
                if (i_msg_valid && state.msg_ready) begin
                    next_state.cap_addr = i_msg_desc_addr;
                    next_state.cap_info = i_msg_desc_info;
                    next_state.phase    = PH_DESC;
                end
            end
            PH_DESC: begin
                // RL7 descriptor always stored
                next_state.desc.we   = 1'b1;
                next_state.desc.addr = state.cap_addr;
                next_state.desc.data = state.cap_info;
                next_state.phase     = PH_SET;
            end
            PH_SET: begin
                // Status bit after the descriptor is stored
                set_req          = 1'b1;
                next_state.phase = PH_PTR;
            end
            PH_PTR: begin
                // Pointer moves last, after the status bit
                next_state.dev_ptr = state.cap_addr;
                next_state.phase   = PH_IDLE;
            end
            default: begin
                // Unused encoding returns to idle
                next_state.phase = PH_IDLE;
            end
        endcase
        // Ready only while idle, so one message is in flight
        next_state.msg_ready = (next_state.phase == PH_IDLE);

        // RL1 clear wins over set
        if (ptr_match) begin
            // Matching write clears the pending bit
            next_state.flags[BIT_PENDING] = 1'b0;
        end else if (set_req) begin
            // RL8 normal raise on completion
            next_state.flags[BIT_PENDING] = 1'b1;
        end

        // Software clears event flags by writing ones
        // The pending bit is read only here; only the pointer compare clears it
        if (do_write && (wsel == SEL_STATUS)) begin
            next_state.flags[BIT_MISMATCH] = state.flags[BIT_MISMATCH] & ~w1c[BIT_MISMATCH];
            next_state.flags[BIT_LOST]     = state.flags[BIT_LOST] & ~w1c[BIT_LOST];
        end
        // RL5 mismatch keeps bit pending
        if (ptr_wr && !ptr_match) begin
            next_state.flags[BIT_MISMATCH] = 1'b1;
        end
        // RL6 collision loses the interrupt
        if (ptr_match && set_req) begin
            next_state.flags[BIT_LOST] = 1'b1;
        end

        // Mask register
        // Enables take the written bits under the strobe; a low strobe clears them
        if (do_write && (wsel == SEL_MASK)) begin
            next_state.mask = w1c[FLAG_W-1:0];
        end

        // RL5 pacing countdown re-arms
        if (do_write && (wsel == SEL_PACE)) begin
            // New countdown holds the pending interrupt back
            next_state.pace_cnt = pace_val[PACE_W-1:0];
            next_state.armed    = 1'b0;
        end else if (!state.armed) begin
            if (state.pace_cnt == '0) begin
                // Countdown over; pending bit may drive the output
                next_state.armed = 1'b1;
            end else begin
                // One step per clock
                next_state.pace_cnt = state.pace_cnt - 1'b1;
            end
        end

        // Read channel: answer one cycle after the address is taken
        if (state.rsp.rvalid && i_axi.rready) begin
            // Master has taken the read data
            next_state.rsp.rvalid = 1'b0;
        end
        if (i_axi.arvalid && state.rsp.arready) begin
            // Registers are sampled in the cycle the address is taken
            rsel                  = decode(i_axi.araddr);
            next_state.rsp.rvalid = 1'b1;
            next_state.rsp.rresp  = RESP_OKAY;
            case (rsel)
                SEL_PTR:    next_state.rsp.rdata = state.dev_ptr;
                SEL_PACE:   next_state.rsp.rdata = {{(DATA_W-PACE_W){1'b0}}, state.pace_cnt};
                SEL_STATUS: next_state.rsp.rdata = {{(DATA_W-FLAG_W){1'b0}}, state.flags};
                SEL_MASK:   next_state.rsp.rdata = {{(DATA_W-FLAG_W){1'b0}}, state.mask};
                default: begin
                    // Unmapped read answers zero with an error
                    next_state.rsp.rdata = '0;
                    next_state.rsp.rresp = RESP_SLVERR;
                end
            endcase
        end

        // Ready flags follow what is held
        // Taken from next values so a freed slot is offered at once
        next_state.rsp.awready = !next_state.aw_got && !next_state.rsp.bvalid;
        next_state.rsp.wready  = !next_state.w_got && !next_state.rsp.bvalid;
        next_state.rsp.arready = !next_state.rsp.rvalid;

        // Interrupt: event flags by mask, pending also needs pacing expiry
        // Pacing gates only the pending bit; event flags fire at once
        next_state.irq = (next_state.flags[BIT_PENDING] & next_state.mask[BIT_PENDING]
                          & next_state.armed)
                       | |(next_state.flags[FLAG_W-1:1] & next_state.mask[FLAG_W-1:1]);
    end

    // State register
    // Reset loads constants only; ready outputs start high so the first
    // request after release is taken at once
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            state             <= '0;
            state.phase       <= PH_IDLE;
            state.dev_ptr     <= RST_PTR;
            state.mask        <= RST_MASK;
            state.pace_cnt    <= RST_PACE;
            state.armed       <= 1'b1;
            state.msg_ready   <= 1'b1;
            state.rsp.awready <= 1'b1;
            state.rsp.wready  <= 1'b1;
            state.rsp.arready <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // Outputs straight from the state register
    // No logic between the flip-flops and the pins
    assign o_axi       = state.rsp;
    assign o_desc      = state.desc;
    assign o_msg_ready = state.msg_ready;
    assign o_irq       = state.irq;

endmodule
`default_nettype wire

//--- tb/msg_irq_assertions.sv
// Checker for the message completion interrupt block.
// Sees only the top module ports and is attached by bind.
`timescale 1ns/1ps
`default_nettype none
module msg_irq_assertions
    import msg_irq_pkg::*;
(
    input wire logic                i_clock,
    input wire logic                i_nrst,
    input wire axi_req_t            i_axi,
    input wire axi_rsp_t            o_axi,
    input wire logic                i_msg_valid,
    input wire logic [DATA_W-1:0]   i_msg_desc_addr,
    input wire logic [DATA_W-1:0]   i_msg_desc_info,
    input wire logic                o_msg_ready,
    input wire desc_wr_t            o_desc,
    input wire logic                o_irq
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    logic take;  // Message accepted at this edge
    assign take = i_msg_valid && o_msg_ready;

    // Store step carries the accepted descriptor
    sequence s_store;
        o_desc.we && !o_msg_ready && o_desc.addr == $past(i_msg_desc_addr, 2)
            && o_desc.data == $past(i_msg_desc_info, 2);
    endsequence
    // Set step, then ready again after the pointer step
    sequence s_finish;
        !o_msg_ready ##1 o_msg_ready;
    endsequence

    property p_msg_seq;
        take |=> !o_msg_ready ##1 s_store ##1 s_finish;
    endproperty
    property p_we_pulse;
        o_desc.we |=> !o_desc.we;
    endproperty
    property p_we_cause;
        o_desc.we |-> $past(take, 2);
    endproperty
    property p_irq_fall;
        $fell(o_irq) |-> $rose(o_axi.bvalid);
    endproperty
    property p_wr_resp;
        i_axi.awvalid && o_axi.awready && i_axi.wvalid && o_axi.wready |-> ##2 o_axi.bvalid;
    endproperty
    property p_b_hold;
        o_axi.bvalid && !i_axi.bready |=> o_axi.bvalid && $stable(o_axi.bresp);
    endproperty
    property p_rd_resp;
        i_axi.arvalid && o_axi.arready |=> o_axi.rvalid;
    endproperty
    property p_r_hold;
        o_axi.rvalid && !i_axi.rready |=> o_axi.rvalid && $stable(o_axi.rdata);
    endproperty

    a_msg_seq: assert property (p_msg_seq) else $error("message steps out of order");
    a_we_pulse: assert property (p_we_pulse) else $error("store pulse too long");
    a_we_cause: assert property (p_we_cause) else $error("store without message");
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without write");
    a_wr_resp: assert property (p_wr_resp) else $error("write response late");
    a_b_hold: assert property (p_b_hold) else $error("write response not held");
    a_rd_resp: assert property (p_rd_resp) else $error("read response late");
    a_r_hold: assert property (p_r_hold) else $error("read data not held");
endmodule

bind msg_irq msg_irq_assertions u_msg_irq_assertions (.i_clock(i_clock), .i_nrst(i_nrst), .i_axi(i_axi),
    .o_axi(o_axi), .i_msg_valid(i_msg_valid), .i_msg_desc_addr(i_msg_desc_addr),
    .i_msg_desc_info(i_msg_desc_info), .o_msg_ready(o_msg_ready), .o_desc(o_desc), .o_irq(o_irq));
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the message completion interrupt block.
// Drives the register bus and message port itself; 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import msg_irq_pkg::*;
    logic        i_clock, i_nrst, msg_valid, msg_ready, irq;
    logic [31:0] msg_addr, msg_info, a1, a3;
    axi_req_t    bus;          // Master side of the register bus
    axi_rsp_t    rsp;          // Slave answers
    desc_wr_t    desc;         // Descriptor store
    int          num_errors, num_checks, seed;
    logic [31:0] rd_q[$];      // Expected read data
    logic [63:0] dsc_q[$];     // Expected descriptor stores
    logic [1:0]  rs_q[$];      // Expected response codes

    msg_irq u_msg_irq (.i_clock(i_clock), .i_nrst(i_nrst), .i_axi(bus), .o_axi(rsp),
        .i_msg_valid(msg_valid), .i_msg_desc_addr(msg_addr), .i_msg_desc_info(msg_info),
        .o_msg_ready(msg_ready), .o_desc(desc), .o_irq(irq));

    // 100 ns clock
    initial i_clock = 1'b0;
    always #50 i_clock = ~i_clock;

    // Compare one word
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Compare the interrupt level at a settled point
    task automatic irq_is(input logic exp);
        @(negedge i_clock);
        chk_w({31'h0, irq}, {31'h0, exp});
        @(posedge i_clock);
    endtask

    // Watch outputs and take the oldest note for each result
    always @(negedge i_clock) begin
        logic [63:0] d;
        if (rsp.rvalid && bus.rready) begin
            chk_w(rsp.rdata, rd_q.pop_front());
            chk_w({30'h0, rsp.rresp}, {30'h0, rs_q.pop_front()});
        end
        if (rsp.bvalid && bus.bready) chk_w({30'h0, rsp.bresp}, {30'h0, rs_q.pop_front()});
        if (desc.we) begin
            d = dsc_q.pop_front();
            chk_w(desc.addr, d[63:32]);
            chk_w(desc.data, d[31:0]);
        end
    end

    // Expected response code: mapped registers answer okay
    function automatic logic [1:0] exp_resp(input logic [7:0] a);
        exp_resp = (a inside {OFF_COMP_PTR, OFF_PACING, OFF_STATUS, OFF_MASK}) ? RESP_OKAY : RESP_SLVERR;
    endfunction

    // Register write; each channel released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        aw = 1'b1;
        w = 1'b1;
        b = 1'b0;
        rs_q.push_back(exp_resp(a));
        bus.awaddr <= a;
        bus.wdata <= d;
        bus.wstrb <= 4'hf;
        bus.awvalid <= 1'b1;
        bus.wvalid <= 1'b1;
        bus.bready <= 1'b1;
        while (!b) begin
            @(negedge i_clock);
            aw = aw && !rsp.awready;
            w = w && !rsp.wready;
            b = rsp.bvalid;
            @(posedge i_clock);
            bus.awvalid <= aw;
            bus.wvalid <= w;
            bus.bready <= !b;
        end
        @(posedge i_clock);
    endtask

    // Register read; data checked by the monitor
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic ar, r;
        ar = 1'b1;
        r = 1'b0;
        rd_q.push_back(exp);
        rs_q.push_back(exp_resp(a));
        bus.araddr <= a;
        bus.arvalid <= 1'b1;
        bus.rready <= 1'b1;
        while (!r) begin
            @(negedge i_clock);
            ar = ar && !rsp.arready;
            r = rsp.rvalid;
            @(posedge i_clock);
            bus.arvalid <= ar;
            bus.rready <= !r;
        end
        @(posedge i_clock);
    endtask

    // Offer one finished message; returns at the accepting edge
    task automatic msg(input logic [31:0] a, input logic [31:0] d);
        logic t;
        t = 1'b0;
        dsc_q.push_back({a, d});
        msg_addr <= a;
        msg_info <= d;
        msg_valid <= 1'b1;
        while (!t) begin
            @(negedge i_clock);
            t = msg_ready;
            @(posedge i_clock);
        end
        msg_valid <= 1'b0;
    endtask

    // Print counts and verdict, then stop
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Cut a hang short
    initial begin
        #(5000 * 100);
        num_errors++;
        report_and_stop;
    end

    // Main sequence
    initial begin
        bus = '0;
        msg_valid = 1'b0;
        msg_addr = 32'h0;
        msg_info = 32'h0;
        num_errors = 0;
        num_checks = 0;
        seed = 30;
        i_nrst = 1'b0;
        repeat (4) @(posedge i_clock);
        i_nrst <= 1'b1;
        wr(8'h10, 32'hffff_ffff);
        rd(OFF_COMP_PTR, RST_PTR);
        rd(OFF_PACING, {16'h0, RST_PACE});
        rd(OFF_STATUS, 32'h0);
        rd(OFF_MASK, {29'h0, RST_MASK});
        rd(8'h10, 32'h0);
        $display("test reset done");
        a1 = $random(seed);
        msg(a1, $random(seed));
        repeat (4) @(posedge i_clock);
        irq_is(1'b1);
        rd(OFF_COMP_PTR, a1);
        wr(OFF_COMP_PTR, ~a1);
        irq_is(1'b1);
        rd(OFF_STATUS, 32'h3);
        wr(OFF_STATUS, 32'h3);
        rd(OFF_STATUS, 32'h1);
        wr(OFF_PACING, 32'h5);
        irq_is(1'b0);
        repeat (8) @(posedge i_clock);
        irq_is(1'b1);
        $display("test mismatch done");
        wr(OFF_COMP_PTR, a1);
        irq_is(1'b0);
        rd(OFF_STATUS, 32'h0);
        wr(OFF_MASK, 32'h5);
        a3 = $random(seed);
        msg(a3, $random(seed));
        wr(OFF_COMP_PTR, a1);
        rd(OFF_STATUS, 32'h4);
        irq_is(1'b1);
        rd(OFF_COMP_PTR, a3);
        wr(OFF_STATUS, 32'h4);
        irq_is(1'b0);
        $display("test collision done");
        a3 = $random(seed);
        msg(a3, $random(seed));
        repeat (4) @(posedge i_clock);
        irq_is(1'b1);
        rd(OFF_STATUS, 32'h1);
        wr(OFF_COMP_PTR, a3);
        irq_is(1'b0);
        rd(OFF_COMP_PTR, a3);
        wr(OFF_PACING, 32'h0);
        irq_is(1'b0);
        $display("test recovery done");
        report_and_stop;
    end
endmodule
`default_nettype wire
